//--- inc/aisel_defs.vh
// Constants for the converter input and reference selection block
`ifndef AISEL_DEFS_VH
`define AISEL_DEFS_VH
// ==========================================================
// Register map (byte addresses, one word per register)
`define AISEL_OFS_INPUT_SELECT 8'h07
`define AISEL_IDX_INPUT_SELECT 8'h07
`define AISEL_ADDR_INPUT_SELECT 12'h01C
`define AISEL_ADDR_CONTROL 12'h020
`define AISEL_ADDR_STATUS 12'h024
`define AISEL_RST_INPUT_SELECT 8'h00
// ==========================================================
// Field positions of the input selection register
`define AISEL_REF_HI 7
`define AISEL_REF_LO 6
`define AISEL_CH_HI 5
`define AISEL_CH_LO 0
// Control register bits
`define AISEL_CTL_ENABLE 0
`define AISEL_CTL_START 1
// Status register bits
`define AISEL_ST_BUSY 0
`define AISEL_ST_DONE 1
`define AISEL_ST_LONG 2
// ==========================================================
// Reference codes
`define AISEL_REF_SUPPLY 2'h0
`define AISEL_REF_EXTERNAL 2'h1
`define AISEL_REF_INTERNAL 2'h2
`define AISEL_REF_RESERVED 2'h3
// Channel codes
`define AISEL_CH_GROUND 6'h20
`define AISEL_CH_BANDGAP 6'h21
`define AISEL_CH_TEMP 6'h22
`define AISEL_CH_CAL0_20X 6'h23
// Source selects on the analog path
`define AISEL_SRC_PIN 2'h0
`define AISEL_SRC_GROUND 2'h1
`define AISEL_SRC_BANDGAP 2'h2
`define AISEL_SRC_TEMP 2'h3
// ==========================================================
// Conversion lengths in converter clock cycles
`define AISEL_CONV_NORMAL 5'h0D
`define AISEL_CONV_LONG 5'h19
// Converter clock enable divider, system clocks per converter clock
`define AISEL_CONV_DIV 8'h02
`endif

//--- hdl/aisel_top.v
// Converter input and reference selection with conversion timing
// Contract
// - Two-bit reference field sits in bits 7:6 of the input selection register.
// - Reference 00 supply, 01 external pin, 10 internal 1.1V, 11 reserved.
// - Reference writes during a conversion apply only when it completes.
// - After a reference change the next conversion lasts 25 converter clocks.
// - Six-bit channel and gain field sits in bits 5:0.
// - Channel writes during a conversion apply only when it completes.
// - Codes 000000 to 000111 select single-ended inputs zero to seven.
// - 100000 ground, 100001 internal reference, 100010 temperature sensor enabled.
// - Differential, reversed differential and offset calibration code ranges decode.
// - In differential and offset calibration codes, lowest channel bit picks 1x when clear, 20x when set.
// - Top channel bit swaps polarity of ordinary differential pairs.
// - Differential 1x pair codes map inputs as tabulated.
// - Offset calibration ties inputs zero, three or seven to both sides.
// - Done flag sets when a conversion completes and results update.
// - Normal conversion 13 converter clocks, long one 25.
`timescale 1ns/1ps
`include "aisel_defs.vh"

module aisel_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg [1:0] ref_select,
  output reg ext_ref_connect,
  output reg int_ref_enable,
  output reg [1:0] pos_source,
  output reg [2:0] pos_pin,
  output reg [2:0] neg_pin,
  output reg diff_mode,
  output reg gain_20x,
  output reg temp_sensor_enable,
  output reg conv_busy,
  output reg conv_done_pulse
);

// ==========================================================
// Bus slave
reg [7:0] input_select_register_r;
reg [1:0] ctl_r;
reg done_flag_r;
reg [7:0] shadow_r;
reg long_pending_r;
reg first_conv_r;
reg wr_pend_r;
reg [11:0] wr_addr_r;
reg [31:0] rdata_r;
reg [7:0] div_r;
reg [4:0] conv_cnt_r;
reg [4:0] conv_len_r;
wire addr_ok;
wire conv_tick;
wire conv_end;
wire start_req;
reg [31:0] rdata_nxt;

assign addr_ok = hsel & hready & htrans[1];
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_r;

always @*
begin
  rdata_nxt = 32'h00000000;
  case (haddr[11:0])
    `AISEL_ADDR_INPUT_SELECT: rdata_nxt = {24'h000000, input_select_register_r};
    `AISEL_ADDR_CONTROL: rdata_nxt = {30'h00000000, ctl_r[`AISEL_CTL_START] | conv_busy, ctl_r[`AISEL_CTL_ENABLE]};
    `AISEL_ADDR_STATUS: rdata_nxt = {29'h00000000, long_pending_r, done_flag_r, conv_busy};
    default: rdata_nxt = 32'h00000000;
  endcase
end

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_pend_r <= 1'b0;
    wr_addr_r <= 12'h000;
    rdata_r <= 32'h00000000;
  end
  else
  begin
    wr_pend_r <= addr_ok & hwrite;
    wr_addr_r <= haddr[11:0];
    if (addr_ok & ~hwrite)
      rdata_r <= rdata_nxt;
  end
end

// ==========================================================
// Software registers
// The input selection register always takes writes; only the shadow waits.
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    input_select_register_r <= `AISEL_RST_INPUT_SELECT;
    ctl_r <= 2'h0;
    done_flag_r <= 1'b0;
  end
  else
  begin
    if (wr_pend_r && wr_addr_r == `AISEL_ADDR_INPUT_SELECT)
      input_select_register_r <= hwdata[7:0];
    if (wr_pend_r && wr_addr_r == `AISEL_ADDR_CONTROL)
      ctl_r <= {hwdata[`AISEL_CTL_START], hwdata[`AISEL_CTL_ENABLE]};
    else if (start_req)
      ctl_r[`AISEL_CTL_START] <= 1'b0;
    // Set wins over a write-one-to-clear in the same cycle
    if (conv_end)
      done_flag_r <= 1'b1;
    else if (wr_pend_r && wr_addr_r == `AISEL_ADDR_STATUS && hwdata[`AISEL_ST_DONE])
      done_flag_r <= 1'b0;
  end
end

// ==========================================================
// Conversion timing
assign conv_tick = (div_r == `AISEL_CONV_DIV - 8'h01);
assign start_req = ctl_r[`AISEL_CTL_ENABLE] & ctl_r[`AISEL_CTL_START] & ~conv_busy;
assign conv_end = conv_busy & conv_tick & (conv_cnt_r == conv_len_r - 5'h01);

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    div_r <= 8'h00;
    conv_cnt_r <= 5'h00;
    conv_len_r <= `AISEL_CONV_NORMAL;
    conv_busy <= 1'b0;
    conv_done_pulse <= 1'b0;
    shadow_r <= `AISEL_RST_INPUT_SELECT;
    long_pending_r <= 1'b0;
    first_conv_r <= 1'b1;
  end
  else
  begin
    div_r <= conv_tick ? 8'h00 : div_r + 8'h01;
    conv_done_pulse <= conv_end;
    if (!ctl_r[`AISEL_CTL_ENABLE])
    begin
      // Disabling aborts a conversion; re-enabling forces a long one
      conv_busy <= 1'b0;
      first_conv_r <= 1'b1;
      shadow_r <= input_select_register_r;
    end
    else if (start_req)
    begin
      conv_busy <= 1'b1;
      conv_cnt_r <= 5'h00;
      conv_len_r <= (first_conv_r | long_pending_r) ? `AISEL_CONV_LONG : `AISEL_CONV_NORMAL;
      first_conv_r <= 1'b0;
      long_pending_r <= 1'b0;
    end
    else if (conv_end)
    begin
      conv_busy <= 1'b0;
      shadow_r <= input_select_register_r;
      if (input_select_register_r[`AISEL_REF_HI:`AISEL_REF_LO] != shadow_r[`AISEL_REF_HI:`AISEL_REF_LO])
        long_pending_r <= 1'b1;
    end
    else if (conv_busy && conv_tick)
      conv_cnt_r <= conv_cnt_r + 5'h01;
    // Idle with converter on: a reference change applies at once and marks a long conversion
    if (ctl_r[`AISEL_CTL_ENABLE] && !conv_busy && !start_req &&
        input_select_register_r != shadow_r)
    begin
      shadow_r <= input_select_register_r;
      if (input_select_register_r[`AISEL_REF_HI:`AISEL_REF_LO] != shadow_r[`AISEL_REF_HI:`AISEL_REF_LO])
        long_pending_r <= 1'b1;
    end
  end
end

// ==========================================================
// Analog selection decode from the applied settings
reg [1:0] ref_nxt;
reg [5:0] ch;
reg [2:0] swap_pin;
always @*
begin
  swap_pin = 3'h0;
  ch = shadow_r[`AISEL_CH_HI:`AISEL_CH_LO];
  ref_nxt = shadow_r[`AISEL_REF_HI:`AISEL_REF_LO];
  ref_select = ref_nxt;
  ext_ref_connect = (ref_nxt == `AISEL_REF_EXTERNAL);
  int_ref_enable = (ref_nxt == `AISEL_REF_INTERNAL);
  pos_source = `AISEL_SRC_PIN;
  pos_pin = 3'h0;
  neg_pin = 3'h0;
  diff_mode = 1'b0;
  gain_20x = 1'b0;
  temp_sensor_enable = 1'b0;
  if (ch[5:3] == 3'h0)
    pos_pin = ch[2:0];
  else if (ch == `AISEL_CH_GROUND)
    pos_source = `AISEL_SRC_GROUND;
  else if (ch == `AISEL_CH_BANDGAP)
    pos_source = `AISEL_SRC_BANDGAP;
  else if (ch == `AISEL_CH_TEMP)
  begin
    pos_source = `AISEL_SRC_TEMP;
    temp_sensor_enable = 1'b1;
  end
  else
  begin
    diff_mode = 1'b1;
    gain_20x = ch[0];
    if (ch[5:3] == 3'h4)
    begin
      // Offset calibration: same input on both sides
      gain_20x = (ch == `AISEL_CH_CAL0_20X) ? 1'b1 : ch[0];
      pos_pin = (ch[2:1] == 2'h1) ? 3'h0 : ((ch[2:1] == 2'h2) ? 3'h3 : 3'h7);
      neg_pin = pos_pin;
    end
    else
    begin
      case (ch[4:1])
        4'h4:
        begin
          pos_pin = 3'h0;
          neg_pin = 3'h1;
        end
        4'h5:
        begin
          pos_pin = 3'h0;
          neg_pin = 3'h3;
        end
        4'h6:
        begin
          pos_pin = 3'h1;
          neg_pin = 3'h2;
        end
        4'h7:
        begin
          pos_pin = 3'h1;
          neg_pin = 3'h3;
        end
        4'h8:
        begin
          pos_pin = 3'h2;
          neg_pin = 3'h3;
        end
        4'h9:
        begin
          pos_pin = 3'h3;
          neg_pin = 3'h4;
        end
        4'hA:
        begin
          pos_pin = 3'h3;
          neg_pin = 3'h5;
        end
        4'hB:
        begin
          pos_pin = 3'h3;
          neg_pin = 3'h6;
        end
        4'hC:
        begin
          pos_pin = 3'h3;
          neg_pin = 3'h7;
        end
        4'hD:
        begin
          pos_pin = 3'h4;
          neg_pin = 3'h5;
        end
        4'hE:
        begin
          pos_pin = 3'h5;
          neg_pin = 3'h6;
        end
        4'hF:
        begin
          pos_pin = 3'h6;
          neg_pin = 3'h7;
        end
        default:
        begin
          pos_pin = 3'h0;
          neg_pin = 3'h0;
        end
      endcase
      if (ch[5])
      begin
        // Reversed pair: the same pins with the two sides exchanged
        swap_pin = pos_pin;
        pos_pin = neg_pin;
        neg_pin = swap_pin;
      end
    end
  end
end

endmodule

//--- dv/airs_assertions.sv
// Property checker for the converter input and reference selection block
`timescale 1ns/1ps
module airs_assertions (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire [1:0] ref_select,
  input wire ext_ref_connect,
  input wire int_ref_enable,
  input wire [1:0] pos_source,
  input wire [2:0] pos_pin,
  input wire [2:0] neg_pin,
  input wire diff_mode,
  input wire gain_20x,
  input wire temp_sensor_enable,
  input wire conv_busy,
  input wire conv_done_pulse
);
  // ==========================================================
  // Busy length counter, kept here since repetition cannot reach 50
  reg [7:0] bcnt_r;
  wire [7:0] bcnt_nxt = conv_busy ? bcnt_r + 8'h1 : 8'h0;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bcnt_r <= 8'h0;
    else
      bcnt_r <= bcnt_nxt;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Properties
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero wait okay");
  ext_ref_a: assert property (ext_ref_connect == (ref_select == 2'h1)) else $error("external pin wrong");
  int_ref_a: assert property (int_ref_enable == (ref_select == 2'h2)) else $error("internal ref wrong");
  temp_src_a: assert property (temp_sensor_enable == (pos_source == 2'h3)) else $error("sensor wrong");
  gain_diff_a: assert property (gain_20x |-> diff_mode) else $error("gain without pair");
  hold_sel_a: assert property (conv_busy && $past(conv_busy) |->
    $stable({ref_select, pos_source, pos_pin, neg_pin, gain_20x})) else $error("selection moved in conversion");
  done_pulse_a: assert property (conv_done_pulse |=> !conv_done_pulse) else $error("done pulse too long");
  done_idle_a: assert property (conv_done_pulse |-> !conv_busy) else $error("done while busy");
  busy_max_a: assert property (bcnt_r <= 8'h34) else $error("conversion too long");
  busy_min_a: assert property ($fell(conv_busy) |-> bcnt_r >= 8'h18) else $error("conversion too short");
  cover property (conv_done_pulse);
  cover property (temp_sensor_enable);
  cover property (gain_20x && diff_mode);
endmodule
bind aisel_top airs_assertions u_chk (.hclk, .hresetn, .hreadyout, .hresp, .ref_select, .ext_ref_connect,
  .int_ref_enable, .pos_source, .pos_pin, .neg_pin, .diff_mode, .gain_20x, .temp_sensor_enable, .conv_busy,
  .conv_done_pulse);

//--- dv/adc_input_reference_select_tb.sv
// Testbench for the converter input and reference selection block
`timescale 1ns/1ps
`include "aisel_defs.vh"
module adc_input_reference_select_tb;
  // ==========================================================
  // Stimulus and observed signals
  reg hclk = 1'h0;
  reg hresetn = 1'h0;
  reg hsel = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] rd;
  reg [7:0] bcnt_r = 8'h0;
  reg [7:0] blen_r = 8'h0;
  integer mismatches = 0;
  integer checks = 0;
  integer cyc = 0;
  wire [31:0] hrdata;
  wire hreadyout, ext_ref_connect, int_ref_enable, diff_mode, gain_20x, temp_sensor_enable, conv_busy, conv_done_pulse;
  wire [1:0] ref_select, pos_source;
  wire [2:0] pos_pin, neg_pin;
  aisel_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp(), .ref_select, .ext_ref_connect, .int_ref_enable, .pos_source, .pos_pin, .neg_pin,
    .diff_mode, .gain_20x, .temp_sensor_enable, .conv_busy, .conv_done_pulse);
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  // Busy length in system clocks, plus the hang limit
  always @(posedge hclk)
  begin
    cyc = cyc + 1;
    if (conv_busy === 1'h1)
      bcnt_r <= bcnt_r + 8'h1;
    else if (bcnt_r != 8'h0)
    begin
      blen_r <= bcnt_r;
      bcnt_r <= 8'h0;
    end
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  // ==========================================================
  // Shared tasks
  task conclude;
  begin
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [8*12:1] what);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: %0s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask
  task ahb(input wr, input [11:0] a, input [31:0] wd);
  begin
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  end
  endtask
  // Expected code packs ref, source, pos, neg, pair, gain, sensor; neg ignored off pairs
  task chk_sel(input [7:0] v, input [12:0] e);
  begin
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, {24'h0, v});
    ahb(1'h0, `AISEL_ADDR_INPUT_SELECT, 32'h0);
    chk(rd, {24'h0, v}, "readback");
    chk({19'h0, ref_select, pos_source, pos_pin, neg_pin & {3{e[2]}}, diff_mode, gain_20x, temp_sensor_enable},
      {19'h0, e & (e[2] ? 13'h1FFF : 13'h1FC7)}, "decode");
  end
  endtask
  task conv_wait(input [7:0] exp);
  integer n;
  begin
    n = 0;
    while (conv_done_pulse !== 1'h1 && n < 200)
    begin
      @(posedge hclk);
      n = n + 1;
    end
    @(posedge hclk);
    chk({31'h0, n < 200 && blen_r >= exp - 8'h2 && blen_r <= exp + 8'h2}, 32'h1, "conv length");
  end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
  begin
    ahb(1'h0, `AISEL_ADDR_INPUT_SELECT, 32'h0);
    chk(rd, 32'h0, "reset value");
    ahb(1'h1, 12'h100, 32'hFFFFFFFF);
    ahb(1'h0, 12'h100, 32'h0);
    chk(rd, 32'h0, "unmapped");
  end
  endtask
  task t_decode;
  begin
    chk_sel(8'h47, 13'h09C0);
    chk_sel(8'h83, 13'h10C0);
    chk_sel(8'h20, 13'h0200);
    chk_sel(8'h21, 13'h0400);
    chk_sel(8'hA2, 13'h1601);
    chk_sel(8'h08, 13'h000C);
    chk_sel(8'h09, 13'h000E);
    chk_sel(8'h12, 13'h00E4);
    chk_sel(8'h1E, 13'h01BC);
    chk_sel(8'h28, 13'h0044);
    chk_sel(8'h3F, 13'h01F6);
    chk_sel(8'h23, 13'h0006);
    chk_sel(8'h26, 13'h01FC);
    chk_sel(8'hE4, 13'h18DC);
  end
  endtask
  // Changes made mid-conversion wait for completion; a new reference forces a long one
  task t_timing;
  begin
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, 32'h0);
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h3);
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, 32'h83);
    chk({26'h0, conv_busy, ref_select, pos_pin}, 32'h20, "held");
    conv_wait(8'h32);
    chk({27'h0, ref_select, pos_pin}, 32'h13, "applied");
    ahb(1'h0, `AISEL_ADDR_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2, "done flag");
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h3);
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, 32'h85);
    chk({29'h0, pos_pin}, 32'h3, "held pin");
    conv_wait(8'h32);
    chk({29'h0, pos_pin}, 32'h5, "new pin");
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h3);
    conv_wait(8'h1A);
  end
  endtask
  // Off, change, on again forces a long conversion; an idle reference change marks one too
  task t_restart;
  begin
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h0);
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, 32'h88);
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h3);
    conv_wait(8'h32);
    chk({25'h0, diff_mode, pos_pin, neg_pin}, 32'h41, "pair applied");
    ahb(1'h1, `AISEL_ADDR_STATUS, 32'h2);
    ahb(1'h0, `AISEL_ADDR_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h0, "done clear");
    ahb(1'h1, `AISEL_ADDR_INPUT_SELECT, 32'h05);
    ahb(1'h0, `AISEL_ADDR_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4, "long marked");
    chk({27'h0, ref_select, pos_pin}, 32'h5, "idle applied");
    ahb(1'h1, `AISEL_ADDR_CONTROL, 32'h3);
    conv_wait(8'h32);
  end
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_decode;
    t_timing;
    t_restart;
    conclude;
  end
endmodule
